/* File: logic/rx_packet_group_latency.sv */
/*
  Receive packet group engine: signature detect, tag extraction (standard,
  wide, split), per-cell latency statistics and sequence checking.
  Assumes a 32-bit word stream synchronous to clk, fields 4-byte aligned,
  timestamp in the last word, timestamps in clk ticks.
*/
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "rx_pg_defs.svh"
module rx_packet_group_latency (
  input wire logic clk, // 50 MHz clock
  input wire logic nrst, // Sync reset, low
  input wire logic [7:0] regAddr, // Register word address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [31:0] regRdata, // Read data, cycle after strobe
  input wire logic rxValid, // Word valid
  input wire logic rxSof, // First word of frame
  input wire logic rxEof, // Last word, holds timestamp
  input wire logic [31:0] rxData, // Frame word
  input wire logic floatEnd, // Word after float match
  input wire logic ipStart, // First IP header word
  input wire logic protoStart, // First protocol header word
  output logic tagValid, // Pulse: valid tag at frame end
  output logic [31:0] tagOut, // Last valid tag
  output logic seqError // Pulse: sequence error
);
  import rx_pg_pkg::*;

  // ----------------------------------------------------------------
  // Packing of split regions
  // ----------------------------------------------------------------
  function automatic logic [37:0] squeeze(input logic [31:0] val, input logic [31:0] msk);
    logic [31:0] p;
    logic [5:0] w;
    p = `ZERO32;
    w = 6'h00;
    for (int b = 0; b < 32; b++) begin
      if (!msk[b]) begin
        p[w[4:0]] = val[b];
        w = w + 6'h01;
      end
    end
    return {w, p};
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl, sig, next_sig, tagMask, next_tagMask;
  logic [31:0] bucketDur, next_bucketDur, timCfg, next_timCfg;
  logic [15:0] sigOff, next_sigOff, seqOff, next_seqOff;
  logic [17:0] regCfg [0:`NREG-1];
  logic [17:0] next_regCfg [0:`NREG-1];
  logic [31:0] regMask [0:`NREG-1];
  logic [31:0] next_regMask [0:`NREG-1];
  logic [5:0] cellSel, next_cellSel;
  logic clrStat, clrSeq;

  always_comb begin
    next_ctrl = ctrl;
    next_sig = sig;
    next_tagMask = tagMask;
    next_bucketDur = bucketDur;
    next_timCfg = timCfg;
    next_sigOff = sigOff;
    next_seqOff = seqOff;
    next_cellSel = cellSel;
    for (int i = 0; i < `NREG; i++) begin
      next_regCfg[i] = regCfg[i];
      next_regMask[i] = regMask[i];
    end
    clrStat = 1'b0;
    clrSeq = 1'b0;
    if (regWrite) begin
      case (regAddr)
        `A_CTRL: next_ctrl = regWdata;
        `A_SIG: next_sig = regWdata;
        `A_SIGOFF: next_sigOff = regWdata[15:0];
        `A_SEQOFF: next_seqOff = regWdata[15:0];
        `A_MASK: next_tagMask = regWdata;
        `A_BDUR: next_bucketDur = regWdata;
        `A_TIM: next_timCfg = regWdata;
        `A_RCFG1: next_regCfg[0] = regWdata[17:0];
        `A_RCFG2: next_regCfg[1] = regWdata[17:0];
        `A_RCFG3: next_regCfg[2] = regWdata[17:0];
        `A_RMSK1: next_regMask[0] = regWdata;
        `A_RMSK2: next_regMask[1] = regWdata;
        `A_RMSK3: next_regMask[2] = regWdata;
        `A_CSEL: next_cellSel = regWdata[5:0];
        `A_CMD: begin
          clrStat = regWdata[`CMD_CLRSTAT];
          clrSeq = regWdata[`CMD_CLRSEQ];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= `ZERO32;
      sig <= `ZERO32;
      tagMask <= `ZERO32;
      bucketDur <= `ZERO32;
      timCfg <= `ZERO32;
      sigOff <= 16'h0000;
      seqOff <= 16'h0000;
      cellSel <= 6'h00;
      for (int i = 0; i < `NREG; i++) begin
        regCfg[i] <= 18'h0_0000;
        regMask[i] <= `ZERO32;
      end
    end else begin
      ctrl <= next_ctrl;
      sig <= next_sig;
      tagMask <= next_tagMask;
      bucketDur <= next_bucketDur;
      timCfg <= next_timCfg;
      sigOff <= next_sigOff;
      seqOff <= next_seqOff;
      cellSel <= next_cellSel;
      for (int i = 0; i < `NREG; i++) begin
        regCfg[i] <= next_regCfg[i];
        regMask[i] <= next_regMask[i];
      end
    end
  end

  logic [1:0] mode, tim;
  logic [2:0] shf;
  logic en, bktOn, wideMode;
  assign mode = ctrl[`C_MODE_HI:`C_MODE_LO];
  assign tim = ctrl[`C_TIM_HI:`C_TIM_LO];
  assign shf = ctrl[`C_SHF_HI:`C_SHF_LO];
  assign en = ctrl[`C_EN];
  assign wideMode = (mode == `M_WIDE);
  assign bktOn = ctrl[`C_BKT] && !wideMode;

  // ----------------------------------------------------------------
  // Frame parsing
  // ----------------------------------------------------------------
  frame_e state, next_state;
  logic [15:0] wordCnt, next_wordCnt, cur;
  logic [15:0] fltIdx, next_fltIdx, ipIdx, next_ipIdx, proIdx, next_proIdx;
  logic fltSeen, next_fltSeen, ipSeen, next_ipSeen, proSeen, next_proSeen;
  logic sigSeen, next_sigSeen, tagGot, next_tagGot;
  logic [31:0] tagWord, next_tagWord, seqWord, next_seqWord;
  logic [31:0] sofTime, next_sofTime, now;
  logic [31:0] regWord [0:`NREG-1];
  logic [31:0] next_regWord [0:`NREG-1];
  logic [15:0] refBase [0:`NREG-1];
  logic refOk [0:`NREG-1];
  logic inFrame;

  assign cur = rxSof ? 16'h0000 : wordCnt;
  assign inFrame = rxValid && (rxSof || state == S_FRAME);

  always_comb begin
    for (int i = 0; i < `NREG; i++) begin
      case (regCfg[i][`RC_REF_HI:`RC_REF_LO])
        `REF_SOF: begin
          refBase[i] = 16'h0000;
          refOk[i] = 1'b1;
        end
        `REF_FLT: begin
          refBase[i] = floatEnd ? cur : fltIdx;
          refOk[i] = floatEnd || (fltSeen && !rxSof);
        end
        `REF_IP: begin
          refBase[i] = ipStart ? cur : ipIdx;
          refOk[i] = ipStart || (ipSeen && !rxSof);
        end
        default: begin
          refBase[i] = protoStart ? cur : proIdx;
          refOk[i] = protoStart || (proSeen && !rxSof);
        end
      endcase
    end
  end

  always_comb begin
    next_state = state;
    next_wordCnt = wordCnt;
    next_fltIdx = fltIdx;
    next_ipIdx = ipIdx;
    next_proIdx = proIdx;
    next_fltSeen = fltSeen;
    next_ipSeen = ipSeen;
    next_proSeen = proSeen;
    next_sigSeen = sigSeen;
    next_tagGot = tagGot;
    next_tagWord = tagWord;
    next_seqWord = seqWord;
    next_sofTime = sofTime;
    for (int i = 0; i < `NREG; i++) begin
      next_regWord[i] = regWord[i];
    end
    if (inFrame) begin
      if (rxSof) begin
        next_state = S_FRAME;
        next_sigSeen = 1'b0;
        next_tagGot = 1'b0;
        next_fltSeen = 1'b0;
        next_ipSeen = 1'b0;
        next_proSeen = 1'b0;
        next_sofTime = now;
        for (int i = 0; i < `NREG; i++) begin
          next_regWord[i] = `ZERO32;
        end
      end
      next_wordCnt = cur + 16'h0001;
      if (floatEnd) begin
        next_fltIdx = cur;
        next_fltSeen = 1'b1;
      end
      if (ipStart) begin
        next_ipIdx = cur;
        next_ipSeen = 1'b1;
      end
      if (protoStart) begin
        next_proIdx = cur;
        next_proSeen = 1'b1;
      end
      if (cur == sigOff && rxData == sig && !rxEof) begin
        next_sigSeen = 1'b1;
      end
      if (sigSeen && !rxSof && cur == sigOff + 16'h0001) begin
        next_tagWord = rxData;
        next_tagGot = 1'b1;
      end
      if (cur == seqOff && !rxEof) begin
        next_seqWord = rxData;
      end
      for (int i = 0; i < `NREG; i++) begin
        if (refOk[i] && cur == refBase[i] + {2'b00,
            regCfg[i][`RC_OFF_HI:`RC_WORD_LO]}) begin
          next_regWord[i] = rxData;
        end
      end
      if (rxEof) begin
        next_state = S_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= S_IDLE;
      wordCnt <= 16'h0000;
      fltIdx <= 16'h0000;
      ipIdx <= 16'h0000;
      proIdx <= 16'h0000;
      fltSeen <= 1'b0;
      ipSeen <= 1'b0;
      proSeen <= 1'b0;
      sigSeen <= 1'b0;
      tagGot <= 1'b0;
      tagWord <= `ZERO32;
      seqWord <= `ZERO32;
      sofTime <= `ZERO32;
      now <= `ZERO32;
      for (int i = 0; i < `NREG; i++) begin
        regWord[i] <= `ZERO32;
      end
    end else begin
      state <= next_state;
      wordCnt <= next_wordCnt;
      fltIdx <= next_fltIdx;
      ipIdx <= next_ipIdx;
      proIdx <= next_proIdx;
      fltSeen <= next_fltSeen;
      ipSeen <= next_ipSeen;
      proSeen <= next_proSeen;
      sigSeen <= next_sigSeen;
      tagGot <= next_tagGot;
      tagWord <= next_tagWord;
      seqWord <= next_seqWord;
      sofTime <= next_sofTime;
      now <= now + 32'h0000_0001;
      for (int i = 0; i < `NREG; i++) begin
        regWord[i] <= next_regWord[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Tag build, latency, time buckets and sequence check
  // ----------------------------------------------------------------
  logic frameEnd, tagOk, idxOk, seqBad, bucketTick, bktDone, next_bktDone;
  logic [31:0] tagVal, lat, lenTicks, preTicks, bktTimer, next_bktTimer;
  logic [37:0] sq1, sq2, sq3;
  logic [5:0] idx, bucket, next_bucket, maxB;
  logic [7:0] byteTicks;

  assign frameEnd = inFrame && rxEof;
  assign byteTicks = timCfg[`TIM_BYTE_HI:`TIM_BYTE_LO];
  assign sq1 = squeeze(regWord[0], regMask[0]);
  assign sq2 = squeeze(regWord[1], regMask[1]);
  assign sq3 = squeeze(regWord[2], regMask[2]);
  assign lenTicks = 32'((32'(cur) + 32'h0000_0001) * `WORD_BYTES * 32'(byteTicks));
  assign preTicks = 32'(32'(timCfg[`TIM_PRE_HI:0]) * 32'(byteTicks));
  assign maxB = `CELL_TOP >> (`CELL_AW3 - shf);
  assign bucketTick = (bktTimer + 32'h0000_0001) >= bucketDur;

  always_comb begin
    case (mode)
      `M_STD: tagVal = (tagWord >> `STD_TAG_W) & ~tagMask & `STD_MSK;
      `M_WIDE: tagVal = tagWord & ~tagMask & `WIDE_MSK;
      default: tagVal = sq1[31:0] | 32'(sq2[31:0] << sq1[37:32])
          | 32'(sq3[31:0] << ({1'b0, sq1[37:32]} + {1'b0, sq2[37:32]}));
    endcase
    tagOk = sigSeen && (mode == `M_SPLIT || tagGot);
    case (tim)
      `T_CT: lat = sofTime - rxData;
      `T_SF: lat = sofTime - (rxData + lenTicks);
      `T_SFP: lat = (sofTime - preTicks) - (rxData + lenTicks);
      default: lat = `ZERO32;
    endcase
    if (bktOn) begin
      idx = 6'((bucket << (`CELL_AW3 - shf)) | (tagVal[5:0] >> shf));
      idxOk = (tagVal >> `CELL_AW) == `ZERO32 && !bktDone;
    end else begin
      idx = tagVal[5:0];
      idxOk = (tagVal >> `CELL_AW) == `ZERO32;
    end
  end

  always_comb begin
    next_bktTimer = bktTimer;
    next_bucket = bucket;
    next_bktDone = bktDone;
    if (!(en && bktOn) || clrStat) begin
      next_bktTimer = `ZERO32;
      next_bucket = 6'h00;
      next_bktDone = 1'b0;
    end else if (bucketTick) begin
      next_bktTimer = `ZERO32;
      if (bucket == maxB) begin
        next_bktDone = 1'b1;
      end else begin
        next_bucket = bucket + 6'h01;
      end
    end else begin
      next_bktTimer = bktTimer + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Sequence state, update stage and outputs
  // ----------------------------------------------------------------
  logic seqInit, next_seqInit, updValid, next_updValid, next_seqError, next_tagValid;
  logic [31:0] lastSeq, next_lastSeq, updLat, updTs, updRx, next_tagOut, next_regRdata;
  logic [15:0] seqErrs, next_seqErrs;
  logic [5:0] updIdx;
  logic seqEv;

  assign seqBad = seqInit && seqWord != lastSeq + 32'h0000_0001;
  assign seqEv = frameEnd && sigSeen && en;
  assign next_updValid = frameEnd && tagOk && idxOk && en;
  assign next_tagValid = frameEnd && tagOk;
  assign next_tagOut = next_tagValid ? tagVal : tagOut;
  assign next_seqError = seqEv && seqBad;

  always_comb begin
    next_seqInit = seqInit;
    next_lastSeq = lastSeq;
    next_seqErrs = seqErrs;
    if (clrSeq) begin
      next_seqInit = 1'b0;
      next_seqErrs = 16'h0000;
    end
    if (seqEv) begin
      next_seqInit = 1'b1;
      next_lastSeq = seqWord;
      if (seqBad) begin
        next_seqErrs = clrSeq ? 16'h0001
            : (seqErrs == `CNT_MAX ? `CNT_MAX : seqErrs + 16'h0001);
      end
    end
  end

  cell_s mem [0:`CELL_NUM-1];
  cell_s c, nc, rc;
  logic [32:0] sumExt;
  logic [31:0] useLat;
  logic doStat, gap;
  logic [15:0] cntBefore;

  assign c = mem[updIdx];
  assign rc = mem[cellSel];
  assign cntBefore = c.count;
  assign gap = (tim == `T_GAP);
  assign doStat = !(gap && !c.seen);
  assign useLat = gap ? updTs - c.lastTs : updLat;
  assign sumExt = {1'b0, c.sum} + {1'b0, useLat};

  always_comb begin
    nc = c;
    nc.seen = 1'b1;
    nc.lastTs = updTs;
    nc.lastRx = updRx;
    if (!c.seen) begin
      nc.firstRx = updRx;
    end
    if (doStat) begin
      nc.count = c.count == `CNT_MAX ? `CNT_MAX : c.count + 16'h0001;
      nc.min = (c.count == 16'h0000 || useLat < c.min) ? useLat : c.min;
      nc.max = (c.count == 16'h0000 || useLat > c.max) ? useLat : c.max;
      nc.sum = sumExt[32] ? `SUM_MAX : sumExt[31:0];
    end
  end

  always_comb begin
    next_regRdata = `ZERO32;
    if (regRead) begin
      case (regAddr)
        `A_CTRL: next_regRdata = ctrl;
        `A_SIG: next_regRdata = sig;
        `A_SIGOFF: next_regRdata = {16'h0000, sigOff};
        `A_SEQOFF: next_regRdata = {16'h0000, seqOff};
        `A_MASK: next_regRdata = tagMask;
        `A_BDUR: next_regRdata = bucketDur;
        `A_TIM: next_regRdata = timCfg;
        `A_STAT: next_regRdata = {bktDone, 9'h000, bucket, seqErrs};
        `A_CCNT: next_regRdata = {16'h0000, rc.count};
        `A_CMIN: next_regRdata = rc.min;
        `A_CMAX: next_regRdata = rc.max;
        `A_CSUM: next_regRdata = rc.sum;
        `A_CFIRST: next_regRdata = rc.firstRx;
        `A_CLAST: next_regRdata = rc.lastRx;
        `A_TAG: next_regRdata = tagOut;
        default: next_regRdata = `ZERO32;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || clrStat) begin
      for (int i = 0; i < `CELL_NUM; i++) begin
        mem[i] <= '0;
      end
    end
    if (nrst && updValid) begin
      mem[updIdx] <= nc;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bktTimer <= `ZERO32;
      bucket <= 6'h00;
      bktDone <= 1'b0;
      seqInit <= 1'b0;
      lastSeq <= `ZERO32;
      seqErrs <= 16'h0000;
      updValid <= 1'b0;
      updIdx <= 6'h00;
      updLat <= `ZERO32;
      updTs <= `ZERO32;
      updRx <= `ZERO32;
      tagValid <= 1'b0;
      tagOut <= `ZERO32;
      seqError <= 1'b0;
      regRdata <= `ZERO32;
    end else begin
      bktTimer <= next_bktTimer;
      bucket <= next_bucket;
      bktDone <= next_bktDone;
      seqInit <= next_seqInit;
      lastSeq <= next_lastSeq;
      seqErrs <= next_seqErrs;
      updValid <= next_updValid;
      updIdx <= idx;
      updLat <= lat;
      updTs <= rxData;
      updRx <= sofTime;
      tagValid <= next_tagValid;
      tagOut <= next_tagOut;
      seqError <= next_seqError;
      regRdata <= next_regRdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_upd;
    updValid && !clrStat && doStat;
  endsequence

  a_sig_gate: assert property (
    tagValid |-> $past(sigSeen) && $past(frameEnd)) else $error("tag without signature");
  a_std_width: assert property (
    tagValid && $past(mode) == `M_STD |-> (tagOut >> `STD_TAG_W) == `ZERO32)
    else $error("standard tag too wide");
  a_wide_width: assert property (
    tagValid && $past(mode) == `M_WIDE |-> (tagOut >> `WIDE_TAG_W) == `ZERO32)
    else $error("wide tag too wide");
  a_wide_nobkt: assert property (
    wideMode && $past(wideMode) |-> bktTimer == `ZERO32 && bucket == 6'h00)
    else $error("buckets run in wide mode");
  a_seq_count: assert property (
    seqError && !$past(clrSeq) && $past(seqErrs) != `CNT_MAX
    |-> seqErrs == $past(seqErrs) + 16'h0001) else $error("sequence error not counted");
  a_seq_sat: assert property (
    seqErrs == `CNT_MAX && !clrSeq |=> seqErrs == `CNT_MAX) else $error("error count wrapped");
  a_cell_count: assert property (
    s_upd ##0 cntBefore != `CNT_MAX |=> mem[$past(updIdx)].count == $past(cntBefore) + 16'h0001)
    else $error("cell count not updated");
  a_cell_minmax: assert property (
    s_upd |=> mem[$past(updIdx)].min <= mem[$past(updIdx)].max) else $error("min above max");
  a_bucket_step: assert property (
    en && bktOn && bucketTick && bucket != maxB && !clrStat
    |=> bucket == $past(bucket) + 6'h01) else $error("bucket did not advance");
endmodule

/* File: logic/rx_pg_defs.svh */
/*
  Constants of the receive packet group engine: register offsets, field
  positions, mode codes and limits. Assumes inclusion by bare name only.
*/
`ifndef RX_PG_DEFS_SVH
`define RX_PG_DEFS_SVH

`define CELL_AW 6
`define CELL_NUM 64
`define CELL_AW3 3'h6
`define CELL_TOP 6'h3F
`define NREG 3

`define A_CTRL 8'h00
`define A_SIG 8'h01
`define A_SIGOFF 8'h02
`define A_SEQOFF 8'h03
`define A_MASK 8'h04
`define A_BDUR 8'h05
`define A_TIM 8'h06
`define A_RCFG1 8'h07
`define A_RCFG2 8'h08
`define A_RCFG3 8'h09
`define A_RMSK1 8'h0A
`define A_RMSK2 8'h0B
`define A_RMSK3 8'h0C
`define A_CMD 8'h0D
`define A_STAT 8'h0E
`define A_CSEL 8'h0F
`define A_CCNT 8'h10
`define A_CMIN 8'h11
`define A_CMAX 8'h12
`define A_CSUM 8'h13
`define A_CFIRST 8'h14
`define A_CLAST 8'h15
`define A_TAG 8'h16

`define C_MODE_HI 1
`define C_MODE_LO 0
`define C_BKT 2
`define C_TIM_HI 4
`define C_TIM_LO 3
`define C_SHF_HI 7
`define C_SHF_LO 5
`define C_EN 8
`define TIM_PRE_HI 7
`define TIM_BYTE_HI 15
`define TIM_BYTE_LO 8
`define RC_OFF_HI 15
`define RC_WORD_LO 2
`define RC_REF_HI 17
`define RC_REF_LO 16
`define CMD_CLRSTAT 0
`define CMD_CLRSEQ 1

`define M_STD 2'h0
`define M_WIDE 2'h1
`define M_SPLIT 2'h2
`define T_CT 2'h0
`define T_SF 2'h1
`define T_SFP 2'h2
`define T_GAP 2'h3
`define REF_SOF 2'h0
`define REF_FLT 2'h1
`define REF_IP 2'h2
`define REF_PRO 2'h3

`define STD_TAG_W 16
`define WIDE_TAG_W 17
`define STD_MSK 32'h0000_FFFF
`define WIDE_MSK 32'h0001_FFFF
`define CNT_MAX 16'hFFFF
`define SUM_MAX 32'hFFFF_FFFF
`define ZERO32 32'h0000_0000
`define WORD_BYTES 32'h0000_0004

`endif

/* File: logic/rx_pg_pkg.sv */
/*
  Types of the receive packet group engine.
  Assumes the constants header is compiled alongside.
*/
package rx_pg_pkg;
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_FRAME = 2'b10} frame_e;
  typedef struct packed {
    logic [15:0] count;
    logic [31:0] min;
    logic [31:0] max;
    logic [31:0] sum;
    logic [31:0] lastTs;
    logic [31:0] firstRx;
    logic [31:0] lastRx;
    logic seen;
  } cell_s;
endpackage

/* File: tb/frame_sender.sv */
/*
  Sending test port model: emits instrumented frames word by word.
  Assumes the receiver samples on rising clk edges.
*/
`timescale 1ns/10ps
module frame_sender (
  input wire logic clk, // Port clock
  output logic rxValid, // Word valid
  output logic rxSof, // First word
  output logic rxEof, // Last word
  output logic [31:0] rxData, // Frame word
  output logic floatEnd, // Float match end
  output logic ipStart, // IP header start
  output logic protoStart // Protocol header start
);
  logic [31:0] w;
  initial begin
    {rxValid, rxSof, rxEof, floatEnd, ipStart, protoStart} = 6'h00;
    rxData = 32'h0000_0000;
  end
  // Header, signature, tag, sequence, padding, timestamp last
  task automatic send(input logic [31:0] sig, tag, seq, ts, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      case (i)
        1: w = sig;
        2: w = tag;
        3: w = seq;
        default: w = 32'h5A5A_0000 + i;
      endcase
      if (i == len - 1) w = ts;
      rxValid <= 1'b1;
      {rxSof, rxEof} <= {i == 0, i == len - 1};
      {floatEnd, ipStart, protoStart} <= {i == 2, i == 2, i == 3};
      rxData <= w;
    end
    @(posedge clk);
    {rxValid, rxSof, rxEof, floatEnd, ipStart, protoStart} <= 6'h00;
    rxData <= ~w;
  endtask
endmodule

/* File: tb/test_rx_packet_group_latency.sv */
/*
  Self-checking bench of the packet group engine.
  Assumes frame_sender as the far side and the register map of the defs.
*/
`timescale 1ns/10ps
`include "rx_pg_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failCount++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_rx_packet_group_latency;
  localparam logic [31:0] SIG = 32'h1234_5678;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata, tagOut, rd, rxData;
  logic rxValid, rxSof, rxEof, floatEnd, ipStart, protoStart, tagValid, seqError;
  int failCount = 0;
  int checked = 0;
  int tagSeen = 0;
  int errSeen = 0;
  logic [31:0] nowRef = 32'h0000_0000;
  logic [31:0] sofAt = 32'h0000_0000;
  always #10 clk = ~clk;
  frame_sender tx (.clk(clk), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
    .rxData(rxData), .floatEnd(floatEnd), .ipStart(ipStart), .protoStart(protoStart));
  rx_packet_group_latency dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof), .rxData(rxData),
    .floatEnd(floatEnd), .ipStart(ipStart), .protoStart(protoStart),
    .tagValid(tagValid), .tagOut(tagOut), .seqError(seqError));
  always @(posedge clk) begin
    tagSeen <= tagSeen + (tagValid === 1'b1);
    errSeen <= errSeen + (seqError === 1'b1);
    // Mirror of the receive time stamp, zero while in reset
    nowRef <= nrst ? nowRef + 32'h0000_0001 : 32'h0000_0000;
    if (rxValid === 1'b1 && rxSof === 1'b1) begin
      sofAt <= nowRef;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    rd = regRdata;
  endtask
  task automatic t_std();
    logic [31:0] mn;
    wr(`A_CTRL, 32'h0000_0100);
    wr(`A_MASK, 32'h0000_0002);
    tx.send(SIG, 32'h0007_BEEF, 32'h0, 32'd40, 6);
    tx.send(SIG, 32'h0007_0000, 32'h1, 32'd57, 6);
    repeat (3) @(posedge clk);
    `CHK("tags", 2, tagSeen)
    `CHK("tag", 32'h0000_0005, tagOut)
    wr(`A_CSEL, 32'h0000_0005);
    rdr(`A_CCNT);
    `CHK("count", 32'h0000_0002, rd)
    rdr(`A_CMIN);
    mn = rd;
    rdr(`A_CMAX);
    `CHK("spread", 32'h0000_000A, rd - mn)
    rdr(`A_CSUM);
    `CHK("sum", mn + mn + 32'h0000_000A, rd)
    rdr(8'h3F);
    `CHK("unmapped", 32'h0000_0000, rd)
  endtask
  task automatic t_wide();
    wr(`A_CTRL, 32'h0000_0105);
    wr(`A_MASK, 32'h0000_0000);
    tx.send(SIG, 32'h0003_0012, 32'h2, 32'd20, 16);
    repeat (2) @(posedge clk);
    `CHK("wide", 32'h0001_0012, tagOut)
  endtask
  task automatic t_split();
    wr(`A_CTRL, 32'h0000_0102);
    wr(`A_RCFG1, 32'h0000_0008);
    wr(`A_RMSK1, 32'hFFFF_FF00);
    wr(`A_RCFG2, 32'h0002_0004);
    wr(`A_RMSK2, 32'hFFFF_FFF0);
    wr(`A_RCFG3, 32'h0003_0000);
    wr(`A_RMSK3, 32'hFFFF_FFF0);
    tx.send(SIG, 32'h0000_00AB, 32'h0000_0003, 32'd20, 6);
    repeat (2) @(posedge clk);
    `CHK("split", 32'h0000_33AB, tagOut)
    tx.send(~SIG, 32'h0000_00CD, 32'h0000_0007, 32'd20, 6);
    repeat (2) @(posedge clk);
    `CHK("nosig", 4, tagSeen)
  endtask
  task automatic t_seq();
    wr(`A_CTRL, 32'h0000_0100);
    wr(`A_CMD, 32'h0000_0002);
    tx.send(SIG, 32'h0001_0000, 32'h0, 32'd20, 6);
    tx.send(SIG, 32'h0001_0000, 32'h2, 32'd20, 6);
    tx.send(SIG, 32'h0001_0000, 32'h1, 32'd20, 6);
    repeat (3) @(posedge clk);
    `CHK("errs", 2, errSeen)
    rdr(`A_STAT);
    `CHK("errcnt", 16'h0002, rd[15:0])
  endtask
  task automatic t_timing();
    logic [31:0] e1, e2, f;
    wr(`A_TIM, 32'h0000_0108);
    wr(`A_CTRL, 32'h0000_0108);
    tx.send(SIG, 32'h0002_0000, 32'h0000_0002, 32'h0000_0000, 6);
    // Six words of four bytes at one tick per byte
    e1 = sofAt - 32'h0000_0018;
    wr(`A_CTRL, 32'h0000_0110);
    tx.send(SIG, 32'h0003_0000, 32'h0000_0003, 32'h0000_0000, 6);
    // Frame length plus eight preamble bytes
    e2 = sofAt - 32'h0000_0020;
    wr(`A_CTRL, 32'h0000_0118);
    tx.send(SIG, 32'h0009_0000, 32'h0000_0004, 32'h0000_0064, 6);
    f = sofAt;
    tx.send(SIG, 32'h0009_0000, 32'h0000_0005, 32'h0000_0082, 6);
    tx.send(SIG, 32'h0009_0000, 32'h0000_0006, 32'h0000_0096, 6);
    repeat (2) @(posedge clk);
    wr(`A_CSEL, 32'h0000_0002);
    rdr(`A_CMIN);
    `CHK("sf", e1, rd)
    wr(`A_CSEL, 32'h0000_0003);
    rdr(`A_CMIN);
    `CHK("sfp", e2, rd)
    wr(`A_CSEL, 32'h0000_0009);
    rdr(`A_CCNT);
    `CHK("gapcnt", 32'h0000_0002, rd)
    rdr(`A_CMIN);
    `CHK("gapmin", 32'h0000_0014, rd)
    rdr(`A_CMAX);
    `CHK("gapmax", 32'h0000_001E, rd)
    rdr(`A_CFIRST);
    `CHK("first", f, rd)
    rdr(`A_CLAST);
    `CHK("last", sofAt, rd)
  endtask
  task automatic t_bucket();
    wr(`A_BDUR, 32'h0000_0032);
    wr(`A_CTRL, 32'h0000_0124);
    rdr(`A_STAT);
    `CHK("bucket0", 16'h0000, rd[31:16])
    tx.send(SIG, 32'h0005_0000, 32'h0000_0007, 32'h0000_0000, 6);
    repeat (120) @(posedge clk);
    rdr(`A_STAT);
    `CHK("bktdone", 16'h8001, rd[31:16])
    wr(`A_CSEL, 32'h0000_0002);
    rdr(`A_CCNT);
    `CHK("shared", 32'h0000_0002, rd)
  endtask
  task automatic giveVerdict();
    $display("checked %0d failCount %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    giveVerdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (80) @(posedge clk);
    wr(`A_SIG, SIG);
    wr(`A_SIGOFF, 32'h0000_0001);
    wr(`A_SEQOFF, 32'h0000_0003);
    wr(`A_CMD, 32'h0000_0003);
    t_std();
    t_wide();
    t_split();
    t_seq();
    t_timing();
    t_bucket();
    giveVerdict();
  end
endmodule
